//--- rtl/mct_modem_ctrl.sv
// Modem control: two configuration words and the behaviour they select.
// Assumes a decoded register port, a signal strength estimate averaged
// over 8 symbols, an address matcher and a byte-wide receive stream.
// Summary of operation
// - Reserved frame types rejected unless acceptance set
// - Acceptance set: reserved types pass, no checks
// - Decode enable resets high; off accepts all
// - Coordinator role accepts frames without destination
// - Margin field bits 10:8, reset two
// - Criterion 1: strength hysteresis decides clear
// - Criterion 2: clear when not receiving; 0 reserved
// - Criterion 3: strength and not receiving, default
// - Auto checksum appends and checks CRC-16
// - Auto acknowledge twelve symbols after good frame
// - Preamble sends field plus one zero bytes
// - Correlator threshold gates start delimiter search
// - Offset filter freezes or updates continuously
// - Phase bit reverses modulation both directions
// - Source 0 buffer; 1 serial pins endless
// - Source 2 loops buffer; 3 random data
// - Sink 0 buffer, 1 pins, 2 loops
// - Signed threshold compared with signed estimate
module mct_modem_ctrl #(
  parameter int unsigned ACK_DELAY_CYC = mct_pkg::ACK_DELAY_CYC
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [5:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  input wire logic [7:0] SIGNAL_STRENGTH,
  input wire logic [7:0] CLEAR_THRESHOLD,
  input wire logic RX_VALID_DATA,
  output logic CLEAR_CHANNEL,
  input wire logic [4:0] CORR_VALUE,
  output logic SFD_SEARCH,
  input wire logic PREAMBLE_MATCH,
  output logic OFFSET_FREEZE,
  output logic PHASE_REVERSE,
  input wire logic [7:0] RX_BYTE,
  input wire logic RX_BYTE_VALID,
  input wire logic RX_LAST,
  input wire logic FRM_ADDR_OK,
  input wire logic FRM_NO_DEST,
  output logic FRM_ACCEPT,
  output logic FRM_REJECT,
  output logic FRM_CRC_OK,
  output logic ACK_SEND,
  output logic [7:0] RXB_DATA,
  output logic RXB_WE,
  output logic RXB_WRAP,
  input wire logic RXB_FULL,
  output logic [7:0] SER_OUT,
  output logic SER_OUT_VALID,
  input wire logic TX_START,
  input wire logic TX_ABORT,
  input wire logic [7:0] TXB_DATA,
  input wire logic TXB_VALID,
  input wire logic TXB_LAST,
  input wire logic [7:0] SER_IN,
  input wire logic SER_IN_VALID,
  output logic SRC_READY,
  output logic TXB_REWIND,
  output logic [7:0] TXO_DATA,
  output logic TXO_VALID,
  input wire logic TXO_READY
);

  // ****************************************************************
  // State and helpers
  // ****************************************************************
  typedef struct packed {
    logic [13:0] mc0;        // First control word, stored bits
    logic [10:0] mc1;        // Second control word, stored bits
    logic [15:0] rdata;      // Read answer
    logic clear;             // Clear channel indication
    logic sfd_search;        // Delimiter search allowed
    logic freeze;            // Offset filter frozen
    logic phase;             // Reversed phase
    mct_pkg::mct_tx_t tx;    // Transmit sequencer
    logic [3:0] pre_cnt;     // Preamble bytes left minus one
    logic [15:0] tx_crc;     // Transmit checksum or random state
    logic [15:0] rx_crc;     // Receive checksum
    logic rx_first;          // Next byte opens a frame
    logic [2:0] ftype;       // Captured frame type
    logic ack_req;           // Captured acknowledge request
    logic accept;            // Frame passed filtering
    logic reject;            // Frame refused by filtering
    logic crc_ok;            // Frame checksum good
    logic ack_pend;          // Acknowledge timer running
    logic [15:0] ack_cnt;    // Acknowledge countdown
    logic ack_send;          // Acknowledge pulse
    logic [7:0] rxb_data;    // Byte to receive buffer
    logic rxb_we;            // Receive buffer write
    logic rxb_wrap;          // Cyclic receive buffer
    logic [7:0] ser_out;     // Byte to serial pins
    logic ser_vld;           // Serial byte strobe
    logic room;              // Output buffer has room this cycle
    logic src_rdy;           // Source may hand over a byte
    logic rewind;            // Loop mode restart pulse
  } mct_state_t;

  mct_state_t s_ff;
  mct_state_t nxt_s;
  mct_pkg::mct_byte_t push;       // Byte into output buffer
  logic buf_ready;                // Room as the buffer itself sees it
  logic [1:0] buf_cnt;            // Words in output buffer
  logic signed [8:0] strength;    // Sign extended estimate
  logic signed [8:0] thr;         // Sign extended threshold
  logic signed [8:0] thr_low;     // Threshold minus margin
  logic below;                    // Under the lower edge
  logic above;                    // At or over threshold
  logic [2:0] ftype_now;          // Frame type of this frame
  logic [2:0] nxt_cnt;            // Buffer fill next cycle
  logic take;                     // Source byte taken

  // Field views
  wire logic res_accept = s_ff.mc0[mct_pkg::RESERVED_FRAME_BIT];
  wire logic coord = s_ff.mc0[mct_pkg::COORDINATOR_ROLE_BIT];
  wire logic adr_dec = s_ff.mc0[mct_pkg::ADDR_DECODE_BIT];
  wire logic [2:0] margin = s_ff.mc0[mct_pkg::MARGIN_LSB +: 3];
  wire logic [1:0] crit = s_ff.mc0[mct_pkg::CRITERION_LSB +: 2];
  wire logic auto_crc = s_ff.mc0[mct_pkg::AUTO_CHECKSUM_BIT];
  wire logic auto_ack = s_ff.mc0[mct_pkg::AUTO_ACKNOWLEDGE_BIT];
  wire logic [3:0] pre_len = s_ff.mc0[mct_pkg::PREAMBLE_LSB +: 4];
  wire logic [4:0] correlator_threshold = s_ff.mc1[mct_pkg::CORRELATOR_LSB +: 5];
  wire logic [1:0] src = s_ff.mc1[mct_pkg::TX_SOURCE_LSB +: 2];
  wire logic [1:0] sink = s_ff.mc1[mct_pkg::RX_SINK_LSB +: 2];

  // One byte through the reflected CRC-16, least significant bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ mct_pkg::CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // Read image of one address; unmapped reads zero
  function automatic logic [15:0] read_word(input logic [5:0] a, input mct_state_t st);
    logic [15:0] r;
    r = 16'h0000;
    if (a == mct_pkg::ADDR_MODEM_CONTROL_FIRST)
      r = {2'h0, st.mc0};
    else if (a == mct_pkg::ADDR_MODEM_CONTROL_SECOND)
      r = {5'h00, st.mc1};
    return r;
  endfunction : read_word

  // Signed comparisons on one extra bit so the margin cannot wrap
  assign strength = $signed({SIGNAL_STRENGTH[7], SIGNAL_STRENGTH});
  assign thr = $signed({CLEAR_THRESHOLD[7], CLEAR_THRESHOLD});
  assign thr_low = thr - $signed({6'h00, margin});
  assign below = strength < thr_low;
  assign above = strength >= thr;
  assign ftype_now = s_ff.rx_first ? RX_BYTE[2:0] : s_ff.ftype;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    nxt_s = s_ff;
    push = '0;
    take = 1'b0;
    nxt_s.accept = 1'b0;
    nxt_s.reject = 1'b0;
    nxt_s.ack_send = 1'b0;
    nxt_s.rxb_we = 1'b0;
    nxt_s.ser_vld = 1'b0;
    nxt_s.rewind = 1'b0;

    // Register port; unused upper bits are simply not stored
    if (REG_WR && REG_ADDR == mct_pkg::ADDR_MODEM_CONTROL_FIRST)
      nxt_s.mc0 = REG_WDATA[13:0];
    if (REG_WR && REG_ADDR == mct_pkg::ADDR_MODEM_CONTROL_SECOND)
      nxt_s.mc1 = REG_WDATA[10:0];
    if (REG_RD)
      nxt_s.rdata = read_word(REG_ADDR, s_ff);

    // Clear channel; the band between edges keeps the old value
    unique case (crit)
      mct_pkg::CRIT_STRENGTH:
        if (above)
          nxt_s.clear = 1'b0;
        else if (below)
          nxt_s.clear = 1'b1;
      mct_pkg::CRIT_CARRIER:
        nxt_s.clear = !RX_VALID_DATA;
      mct_pkg::CRIT_BOTH:
        if (above || RX_VALID_DATA)
          nxt_s.clear = 1'b0;
        else if (below)
          nxt_s.clear = 1'b1;
      2'h0:
        nxt_s.clear = s_ff.clear;  // Reserved code holds
    endcase

    // Demodulator controls
    nxt_s.sfd_search = CORR_VALUE >= correlator_threshold;
    nxt_s.freeze = !s_ff.mc1[mct_pkg::OFFSET_FILTER_BIT] && PREAMBLE_MATCH;
    nxt_s.phase = s_ff.mc1[mct_pkg::PHASE_REVERSE_BIT];

    // Acknowledge countdown; a new frame below that earns an acknowledge restarts it
    if (s_ff.ack_pend)
    begin
      if (s_ff.ack_cnt == 16'h0000)
      begin
        nxt_s.ack_send = 1'b1;
        nxt_s.ack_pend = 1'b0;
      end
      else
        nxt_s.ack_cnt = s_ff.ack_cnt - 16'h0001;
    end

    // Receive path: checksum, frame header, sink
    if (RX_BYTE_VALID)
    begin
      nxt_s.rx_crc = crc_byte(s_ff.rx_crc, RX_BYTE);
      nxt_s.rx_first = 1'b0;
      if (s_ff.rx_first)
      begin
        nxt_s.ftype = RX_BYTE[2:0];
        nxt_s.ack_req = RX_BYTE[5];
      end
      unique case (sink)
        mct_pkg::SINK_BUFFER:
        begin
          nxt_s.rxb_data = RX_BYTE;
          nxt_s.rxb_we = !RXB_FULL;
        end
        mct_pkg::SINK_SERIAL:
        begin
          nxt_s.ser_out = RX_BYTE;
          nxt_s.ser_vld = 1'b1;
        end
        mct_pkg::SINK_LOOP:
        begin
          nxt_s.rxb_data = RX_BYTE;  // Overflow ignored
          nxt_s.rxb_we = 1'b1;
        end
        2'h3:
          nxt_s.rxb_we = 1'b0;       // Reserved sink drops data
      endcase
      if (RX_LAST)
      begin
        nxt_s.rx_first = 1'b1;
        nxt_s.rx_crc = 16'h0000;
        nxt_s.crc_ok = crc_byte(s_ff.rx_crc, RX_BYTE) == 16'h0000;
        if (!adr_dec)
          nxt_s.accept = 1'b1;
        else if (ftype_now[2])
          nxt_s.accept = res_accept;
        else if (FRM_NO_DEST)
          nxt_s.accept = coord;
        else
          nxt_s.accept = FRM_ADDR_OK;
        nxt_s.reject = !nxt_s.accept;
        if (auto_ack && auto_crc && nxt_s.accept && nxt_s.crc_ok
            && (s_ff.rx_first ? RX_BYTE[5] : s_ff.ack_req))
        begin
          nxt_s.ack_pend = 1'b1;
          nxt_s.ack_cnt = 16'(ACK_DELAY_CYC - 1);
        end
      end
    end
    nxt_s.rxb_wrap = (sink == mct_pkg::SINK_LOOP);

    // Transmit sequencer; every push waits for room in the buffer
    unique case (s_ff.tx)
      mct_pkg::TX_IDLE:
        if (TX_START)
        begin
          if (src == mct_pkg::SRC_BUFFER)
          begin
            nxt_s.tx = mct_pkg::TX_PRE;
            nxt_s.pre_cnt = pre_len;
            nxt_s.tx_crc = 16'h0000;
          end
          else
          begin
            nxt_s.tx = mct_pkg::TX_DATA;         // Test modes run endless
            nxt_s.tx_crc = mct_pkg::PRBS_SEED;
          end
        end
      mct_pkg::TX_PRE:
        if (s_ff.room)
        begin
          push = '{valid: 1'b1, data: 8'h00};
          if (s_ff.pre_cnt == 4'h0)
            nxt_s.tx = mct_pkg::TX_DATA;
          else
            nxt_s.pre_cnt = s_ff.pre_cnt - 4'h1;
        end
      mct_pkg::TX_DATA:
        unique case (src)
          mct_pkg::SRC_BUFFER:
            if (TXB_VALID && s_ff.src_rdy)
            begin
              take = 1'b1;
              push = '{valid: 1'b1, data: TXB_DATA};
              nxt_s.tx_crc = crc_byte(s_ff.tx_crc, TXB_DATA);
              if (TXB_LAST)
                nxt_s.tx = auto_crc ? mct_pkg::TX_CRCL : mct_pkg::TX_IDLE;
            end
          mct_pkg::SRC_SERIAL:
            if (SER_IN_VALID && s_ff.src_rdy)
              push = '{valid: 1'b1, data: SER_IN};
          mct_pkg::SRC_LOOP:
            if (s_ff.room)
            begin
              take = TXB_VALID;                   // Underflow sends zero
              push = '{valid: 1'b1, data: TXB_VALID ? TXB_DATA : 8'h00};
              nxt_s.rewind = TXB_VALID && TXB_LAST;
            end
          mct_pkg::SRC_RANDOM:
            if (s_ff.room)
            begin
              push = '{valid: 1'b1, data: s_ff.tx_crc[7:0]};
              nxt_s.tx_crc = crc_byte(s_ff.tx_crc, 8'h00);
            end
        endcase
      mct_pkg::TX_CRCL:
        if (s_ff.room)
        begin
          push = '{valid: 1'b1, data: s_ff.tx_crc[7:0]};
          nxt_s.tx = mct_pkg::TX_CRCH;
        end
      mct_pkg::TX_CRCH:
        if (s_ff.room)
        begin
          push = '{valid: 1'b1, data: s_ff.tx_crc[15:8]};
          nxt_s.tx = mct_pkg::TX_IDLE;
        end
      default:
        nxt_s.tx = mct_pkg::TX_IDLE;
    endcase
    if (TX_ABORT)
      nxt_s.tx = mct_pkg::TX_IDLE;

    // Room is judged one cycle ahead so the ready output is a flop
    nxt_cnt = 3'({1'b0, buf_cnt} + {2'h0, push.valid} - {2'h0, TXO_VALID && TXO_READY});
    nxt_s.room = nxt_cnt < 3'h2;
    nxt_s.src_rdy = nxt_s.room && nxt_s.tx == mct_pkg::TX_DATA
                    && src != mct_pkg::SRC_RANDOM;
  end

  // Register stage
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      s_ff <= '0;
      s_ff.mc0 <= mct_pkg::MC0_RESET;
      s_ff.mc1 <= mct_pkg::MC1_RESET;
      s_ff.rx_first <= 1'b1;
      s_ff.tx <= mct_pkg::TX_IDLE;
    end
    else
      s_ff <= nxt_s;
  end

  // Output buffer toward the modulator
  mct_pair_buf #(.W(8), .DEPTH(2)) u_out_buf (
    .clk(MCLK),
    .rst(RST),
    .in_valid(push.valid),
    .in_data(push.data),
    .in_ready(buf_ready),
    .out_valid(TXO_VALID),
    .out_data(TXO_DATA),
    .out_ready(TXO_READY),
    .count(buf_cnt)
  );

  assign REG_RDATA = s_ff.rdata;
  assign CLEAR_CHANNEL = s_ff.clear;
  assign SFD_SEARCH = s_ff.sfd_search;
  assign OFFSET_FREEZE = s_ff.freeze;
  assign PHASE_REVERSE = s_ff.phase;
  assign FRM_ACCEPT = s_ff.accept;
  assign FRM_REJECT = s_ff.reject;
  assign FRM_CRC_OK = s_ff.crc_ok;
  assign ACK_SEND = s_ff.ack_send;
  assign RXB_DATA = s_ff.rxb_data;
  assign RXB_WE = s_ff.rxb_we;
  assign RXB_WRAP = s_ff.rxb_wrap;
  assign SER_OUT = s_ff.ser_out;
  assign SER_OUT_VALID = s_ff.ser_vld;
  assign SRC_READY = s_ff.src_rdy;
  assign TXB_REWIND = s_ff.rewind;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  wire logic last_in = RX_BYTE_VALID && RX_LAST;

  chk_reserved_reject: assert property (
    last_in && adr_dec && !res_accept && ftype_now[2] |=> FRM_REJECT && !FRM_ACCEPT)
    else $error("reserved frame type not rejected");

  chk_reserved_accept: assert property (
    last_in && adr_dec && res_accept && ftype_now[2] |=> FRM_ACCEPT ##1 !FRM_ACCEPT)
    else $error("reserved frame type not accepted");

  chk_decode_off: assert property (
    last_in && !adr_dec |=> FRM_ACCEPT && !FRM_REJECT)
    else $error("frame filtered with decode off");

  chk_clear_strong: assert property (
    crit == mct_pkg::CRIT_STRENGTH && above |=> !CLEAR_CHANNEL)
    else $error("clear channel kept above threshold");

  chk_clear_busy: assert property (
    crit == mct_pkg::CRIT_BOTH && RX_VALID_DATA |=> !CLEAR_CHANNEL)
    else $error("clear channel while receiving");

  chk_clear_hold: assert property (
    crit == mct_pkg::CRIT_STRENGTH && !above && !below |=> $stable(CLEAR_CHANNEL))
    else $error("clear channel moved inside band");

  chk_preamble_load: assert property (
    s_ff.tx == mct_pkg::TX_IDLE && TX_START && !TX_ABORT && src == mct_pkg::SRC_BUFFER
    |=> s_ff.tx == mct_pkg::TX_PRE && s_ff.pre_cnt == $past(pre_len))
    else $error("preamble count not loaded");

  chk_crc_append: assert property (
    s_ff.tx == mct_pkg::TX_DATA && src == mct_pkg::SRC_BUFFER && take && TXB_LAST
    && auto_crc && !TX_ABORT |=> s_ff.tx == mct_pkg::TX_CRCL)
    else $error("checksum not appended");

  chk_sfd_gate: assert property (
    CORR_VALUE < correlator_threshold |=> !SFD_SEARCH)
    else $error("search opened below threshold");

  chk_push_room: assert property (
    push.valid |-> buf_ready)
    else $error("byte pushed into a full output buffer");

endmodule : mct_modem_ctrl

//--- inc/mct_pkg.sv
// Modem control package: register map, field layout, reset values,
// mode codes and timing figures shared by the modem control block.
// Assumes a 200 MHz core clock and registers reached by 6-bit address.
package mct_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [5:0] ADDR_MODEM_CONTROL_FIRST = 6'h11;  // First modem control word
  localparam logic [5:0] ADDR_MODEM_CONTROL_SECOND = 6'h12; // Second modem control word

  // Reset images of the stored bits
  localparam logic [13:0] MC0_RESET = 14'h0AE2;
  localparam logic [10:0] MC1_RESET = 11'h500;

  // ****************************************************************
  // Field positions, first word
  // ****************************************************************
  localparam int RESERVED_FRAME_BIT = 13;   // Accept reserved frame types
  localparam int COORDINATOR_ROLE_BIT = 12; // Node is network coordinator
  localparam int ADDR_DECODE_BIT = 11;      // Address recognition enable
  localparam int MARGIN_LSB = 8;            // Clear channel margin, 3 bits
  localparam int CRITERION_LSB = 6;         // Clear channel criterion, 2 bits
  localparam int AUTO_CHECKSUM_BIT = 5;     // Append and check CRC
  localparam int AUTO_ACKNOWLEDGE_BIT = 4;  // Automatic acknowledge
  localparam int PREAMBLE_LSB = 0;          // Preamble length, 4 bits

  // ****************************************************************
  // Field positions, second word
  // ****************************************************************
  localparam int CORRELATOR_LSB = 6;        // Correlator threshold, 5 bits
  localparam int OFFSET_FILTER_BIT = 5;     // Offset filter behaviour
  localparam int PHASE_REVERSE_BIT = 4;     // Modulation phase
  localparam int TX_SOURCE_LSB = 2;         // Transmit source, 2 bits
  localparam int RX_SINK_LSB = 0;           // Receive sink, 2 bits

  // Criterion codes
  localparam logic [1:0] CRIT_STRENGTH = 2'h1;
  localparam logic [1:0] CRIT_CARRIER = 2'h2;
  localparam logic [1:0] CRIT_BOTH = 2'h3;

  // Transmit source and receive sink codes
  localparam logic [1:0] SRC_BUFFER = 2'h0;
  localparam logic [1:0] SRC_SERIAL = 2'h1;
  localparam logic [1:0] SRC_LOOP = 2'h2;
  localparam logic [1:0] SRC_RANDOM = 2'h3;
  localparam logic [1:0] SINK_BUFFER = 2'h0;
  localparam logic [1:0] SINK_SERIAL = 2'h1;
  localparam logic [1:0] SINK_LOOP = 2'h2;

  // ****************************************************************
  // Checksum and timing
  // ****************************************************************
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408; // Reflected CRC-16 polynomial
  localparam logic [15:0] PRBS_SEED = 16'hFFFF;     // Nonzero start for random data
  localparam int CLK_NS = 5;                        // Core clock period
  localparam int SYMBOL_NS = 16000;                 // One symbol period
  localparam int ACK_SYMBOLS = 12;                  // Acknowledge turnaround
  localparam int ACK_DELAY_CYC = ACK_SYMBOLS * SYMBOL_NS / CLK_NS;

  // Transmit sequencer, Gray coded along the frame path
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_PRE = 3'h1,
    TX_DATA = 3'h3,
    TX_CRCL = 3'h2,
    TX_CRCH = 3'h6
  } mct_tx_t;

  // Byte on its way to the modulator
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mct_byte_t;

endpackage : mct_pkg

//--- rtl/mct_pair_buf.sv
// Small valid/ready buffer between the transmit sequencer and modulator.
// Assumes the receiver may stall at any time; no word is lost.
module mct_pair_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic [$clog2(DEPTH+1)-1:0] count
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // Storage slots
    logic [PW-1:0] wr;            // Write slot
    logic [PW-1:0] rd;            // Read slot
    logic [CW-1:0] cnt;           // Words held
  } mct_buf_t;

  mct_buf_t s_ff;
  mct_buf_t nxt_s;
  logic push;
  logic pop;

  // Next state: push when not full, pop when receiver takes
  always_comb
  begin
    nxt_s = s_ff;
    push = in_valid && (s_ff.cnt != CW'(DEPTH));
    pop = (s_ff.cnt != '0) && out_ready;
    if (push)
    begin
      nxt_s.mem[s_ff.wr] = in_data;
      nxt_s.wr = (s_ff.wr == PW'(DEPTH-1)) ? '0 : PW'(s_ff.wr + 1'b1);
    end
    if (pop)
    begin
      nxt_s.rd = (s_ff.rd == PW'(DEPTH-1)) ? '0 : PW'(s_ff.rd + 1'b1);
    end
    nxt_s.cnt = CW'(s_ff.cnt + CW'(push) - CW'(pop));
  end

  // Register stage
  always_ff @(posedge clk)
  begin
    if (rst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign in_ready = (s_ff.cnt != CW'(DEPTH));
  assign out_valid = (s_ff.cnt != '0);
  assign out_data = s_ff.mem[s_ff.rd];
  assign count = s_ff.cnt;

endmodule : mct_pair_buf

//--- tb/mct_host_model.sv
// Host model: writes and reads the two configuration words.
// Assumes the bench calls put and get; pins move 1 ns after MCLK rises.
module mct_host_model (
  input wire logic clk,
  output logic [5:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {addr, wdata, wr, rd} = '0;
  // One-cycle write; spare upper bits always sent as zero
  task automatic put(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk) #1;
    addr = a;
    wdata = (a == 6'h11) ? (d & 16'h3FFF) : (d & 16'h07FF);
    wr = 1'b1;
    @(posedge clk) #1;
    wr = 1'b0;
  endtask : put
  // Read answer held until the next read, so a late look is safe
  task automatic get(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk) #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk) #1;
    rd = 1'b0;
    @(posedge clk) #1;
    d = rdata;
  endtask : get
endmodule : mct_host_model

//--- tb/mct_modem_ctrl_tb.sv
// Bench: registers, clear channel, frame filter, modem bits, transmit.
// Assumes the host model owns the register port.
`define CK(n, e, a) begin total_checks++; if ((a) !== (e)) begin errors++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module mct_modem_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic MCLK = 0, RST = 1, REG_WR, REG_RD, RX_VALID_DATA = 0, CLEAR_CHANNEL, SFD_SEARCH;
  logic PREAMBLE_MATCH = 0, OFFSET_FREEZE, PHASE_REVERSE, RX_BYTE_VALID = 0, RX_LAST = 0;
  logic FRM_ADDR_OK = 0, FRM_NO_DEST = 0, FRM_ACCEPT, FRM_REJECT, FRM_CRC_OK, ACK_SEND;
  logic RXB_WE, RXB_WRAP, RXB_FULL = 0, SER_OUT_VALID, TX_START = 0, TX_ABORT = 0;
  logic TXB_VALID = 0, TXB_LAST = 0, SER_IN_VALID = 0, SRC_READY, TXB_REWIND, TXO_VALID;
  logic TXO_READY = 0;
  logic [7:0] SIGNAL_STRENGTH = 0, CLEAR_THRESHOLD = 0, RX_BYTE = 0, RXB_DATA, SER_OUT;
  logic [7:0] TXB_DATA = 0, SER_IN = 0, TXO_DATA;
  logic [5:0] REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA, v;
  logic [4:0] CORR_VALUE = 0;
  logic [7:0] q[$];
  int errors = 0, total_checks = 0;
  mct_host_model host (.clk(MCLK), .addr(REG_ADDR), .wdata(REG_WDATA), .wr(REG_WR),
    .rd(REG_RD), .rdata(REG_RDATA));
  mct_modem_ctrl #(.ACK_DELAY_CYC(20)) dut (.*);
  initial forever #2.5 MCLK = ~MCLK;
  // Modulator stalls every other cycle
  always @(posedge MCLK) #1 TXO_READY = ~TXO_READY;
  task automatic cyc(input int k);
    repeat (k) @(posedge MCLK) #1;
  endtask : cyc
  task automatic conclude;
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic cc(input logic [7:0] s, input logic r, input logic e);
    SIGNAL_STRENGTH = s;
    RX_VALID_DATA = r;
    cyc(2);
    `CK("clear", e, CLEAR_CHANNEL)
  endtask : cc
  // Single last byte; filter verdict stands one cycle
  task automatic fr(input logic [7:0] b, input logic ok, input logic e);
    {RX_BYTE, FRM_ADDR_OK, RX_BYTE_VALID, RX_LAST} = {b, ok, 2'b11};
    cyc(1);
    {RX_BYTE_VALID, RX_LAST} = 2'b00;
    `CK("accept", e, FRM_ACCEPT)
    `CK("reject", ~e, FRM_REJECT)
  endtask : fr
  task automatic t_regs;
    host.get(6'h11, v);
    `CK("word0", 16'h0AE2, v)
    host.get(6'h12, v);
    `CK("word1", 16'h0500, v)
    host.get(6'h13, v);
    `CK("unmapped", 16'h0000, v)
  endtask : t_regs
  task automatic t_clear;
    CLEAR_THRESHOLD = 8'hFE;
    host.put(6'h11, 16'h0A42);
    cc(8'hFB, 0, 1);
    cc(8'hFC, 0, 1);
    cc(8'hFE, 0, 0);
    cc(8'hFC, 0, 0);
    host.put(6'h11, 16'h0A82);
    cc(8'hFE, 1, 0);
    cc(8'hFE, 0, 1);
    host.put(6'h11, 16'h0AC2);
    cc(8'hFB, 1, 0);
    cc(8'hFB, 0, 1);
  endtask : t_clear
  task automatic t_filter;
    fr(8'h04, 1, 0);
    host.put(6'h11, 16'h2AC2);
    fr(8'h05, 0, 1);
    host.put(6'h11, 16'h02C2);
    fr(8'h06, 0, 1);
    host.put(6'h11, 16'h1AC2);
    FRM_NO_DEST = 1;
    fr(8'h01, 0, 1);
    `CK("crc_bad", 1'b0, FRM_CRC_OK)
    host.put(6'h11, 16'h0AC2);
    fr(8'h01, 0, 0);
    FRM_NO_DEST = 0;
  endtask : t_filter
  // Good frame asking for acknowledge, then the three receive sinks
  task automatic t_rx;
    host.put(6'h11, 16'h0AF2);
    {RX_BYTE, RX_BYTE_VALID} = {8'h21, 1'b1};
    cyc(1);
    RX_BYTE = 8'h8B;
    cyc(1);
    fr(8'h30, 1, 1);
    `CK("crc_ok", 10'h330, {FRM_CRC_OK, RXB_WE, RXB_DATA})
    cyc(19);
    `CK("ack_early", 1'b0, ACK_SEND)
    cyc(1);
    `CK("ack", 1'b1, ACK_SEND)
    host.put(6'h12, 16'h0501);
    fr(8'h19, 1, 1);
    `CK("serial_out", 10'h119, {RXB_WE, SER_OUT_VALID, SER_OUT})
    RXB_FULL = 1;
    host.put(6'h12, 16'h0502);
    fr(8'h19, 1, 1);
    `CK("wrap", 2'h3, {RXB_WE, RXB_WRAP})
    host.put(6'h12, 16'h0500);
    fr(8'h19, 1, 1);
    `CK("full", 2'h0, {RXB_WE, RXB_WRAP})
    RXB_FULL = 0;
  endtask : t_rx
  // One endless test source: first byte out, still running, abort drains
  task automatic tm(input logic [15:0] w, input logic [9:0] e);
    host.put(6'h12, w);
    TX_START = 1;
    cyc(1);
    TX_START = 0;
    cyc(1);
    `CK("source", e, {TXB_REWIND, TXO_VALID, TXO_DATA})
    cyc(30);
    `CK("endless", 1'b1, TXO_VALID)
    TX_ABORT = 1;
    cyc(1);
    TX_ABORT = 0;
    cyc(6);
    `CK("drained", 2'h0, {TXO_VALID, SRC_READY})
  endtask : tm
  task automatic t_mode;
    {SER_IN, SER_IN_VALID} = {8'hA5, 1'b1};
    tm(16'h0504, 10'h1A5);
    tm(16'h050C, {2'b01, mct_pkg::PRBS_SEED[7:0]});
    {TXB_DATA, TXB_VALID, TXB_LAST} = {8'h77, 2'b11};
    tm(16'h0508, 10'h377);
    {TXB_VALID, TXB_LAST, SER_IN_VALID} = 3'b000;
  endtask : t_mode
  task automatic t_modem;
    host.put(6'h12, 16'h0530);
    {PREAMBLE_MATCH, CORR_VALUE} = {1'b1, 5'h13};
    cyc(2);
    `CK("phase", 1'b1, PHASE_REVERSE)
    `CK("freeze", 1'b0, OFFSET_FREEZE)
    `CK("search", 1'b0, SFD_SEARCH)
    CORR_VALUE = 5'h14;
    host.put(6'h12, 16'h0500);
    cyc(1);
    `CK("phase", 1'b0, PHASE_REVERSE)
    `CK("search", 1'b1, SFD_SEARCH)
    `CK("freeze", 1'b1, OFFSET_FREEZE)
  endtask : t_modem
  // Preamble of four, one data byte, checksum must leave zero residue
  task automatic t_tx;
    logic [15:0] c;
    c = 16'h0000;
    host.put(6'h11, 16'h0A63);
    {TXB_DATA, TXB_VALID, TXB_LAST, TX_START} = {8'h5A, 3'b111};
    cyc(1);
    TX_START = 0;
    repeat (80)
    begin
      @(negedge MCLK);
      if (TXO_VALID && TXO_READY) q.push_back(TXO_DATA);
      if (TXB_VALID && SRC_READY)
      begin
        cyc(1);
        {TXB_VALID, TXB_LAST} = 2'b00;
      end
    end
    `CK("count", 7, q.size())
    `CK("lead", 40'h000000005A, {q[0], q[1], q[2], q[3], q[4]})
    for (int j = 4; j < 7; j++)
      for (int k = 0; k < 8; k++)
        c = (c >> 1) ^ ((c[0] ^ q[j][k]) ? mct_pkg::CRC_POLY_REFL : 16'h0000);
    `CK("residue", 16'h0000, c)
  endtask : t_tx
  initial
  begin
    #20000;
    errors++;
    conclude();
  end
  initial
  begin
    repeat (6) @(posedge MCLK);
    #1 RST = 0;
    t_regs();
    t_clear();
    t_filter();
    t_modem();
    t_tx();
    t_rx();
    t_mode();
    conclude();
  end
endmodule : mct_modem_ctrl_tb
